//--- hhc_pkg.sv
// package for the harmonic heterodyne measurement controller
package hhc_pkg;
   localparam int FREQ_WIDTH = 40;
   localparam int HARM_WIDTH = 8;
   localparam int OFFSET_KHZ = 500;
   localparam int STEP_KHZ = 100;
   localparam int START_KHZ = 350000;
   localparam int STOP_KHZ = 300000;
   localparam int IF_LOW_MHZ = 50;
   localparam int IF_HIGH_MHZ = 100;
   localparam logic [FREQ_WIDTH-1:0] HZ_PER_KHZ = 40'h00000003E8;
   localparam logic [FREQ_WIDTH-1:0] OFFSET_HZ = 40'h000007A120;
   localparam logic [FREQ_WIDTH-1:0] STEP_HZ = 40'h00000186A0;
   localparam logic [FREQ_WIDTH-1:0] START_HZ = 40'h0014DC9380;
   localparam logic [FREQ_WIDTH-1:0] STOP_HZ = 40'h0011E1A300;

   typedef enum {
      HHC_IDLE,
      HHC_SWEEP,
      HHC_SETTLE,
      HHC_COUNT1,
      HHC_RETUNE,
      HHC_COUNT2,
      HHC_DIVIDE,
      HHC_ROUND,
      HHC_RESULT,
      HHC_FAIL
   } hhc_state_type;

   typedef struct packed {
      logic load;
      logic [FREQ_WIDTH-1:0] frequency;
   } hhc_synth_type;

   typedef struct packed {
      logic start;
      logic [FREQ_WIDTH-1:0] count;
   } hhc_count_type;

   typedef struct packed {
      logic valid;
      logic negative_if;
      logic [HARM_WIDTH-1:0] harmonic;
      logic [FREQ_WIDTH-1:0] unknown_input_frequency;
   } hhc_result_type;
endpackage

//--- hhc_compute.sv
// measurement sequencer and arithmetic for the harmonic heterodyne counter
module hhc_compute
   import hhc_pkg::*;
#(
   parameter int SETTLE_CYCLES = 16
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic if_in_band,
   output hhc_pkg::hhc_synth_type synth,
   output hhc_pkg::hhc_count_type counter_cmd,
   input wire logic count_done,
   input wire logic [hhc_pkg::FREQ_WIDTH-1:0] count_value,
   output hhc_pkg::hhc_result_type result,
   output logic busy,
   output logic no_signal
);
   import hhc_pkg::*;

   localparam int DIV_STEPS = FREQ_WIDTH;

   hhc_state_type state;
   logic [2:0] band_sync;
   logic band_ok;
   logic [FREQ_WIDTH-1:0] sweep_frequency;
   logic [FREQ_WIDTH-1:0] first_local_frequency;
   logic [FREQ_WIDTH-1:0] second_local_frequency;
   logic [FREQ_WIDTH-1:0] first_intermediate_count;
   logic [FREQ_WIDTH-1:0] second_intermediate_count;
   logic [FREQ_WIDTH-1:0] quotient;
   logic [FREQ_WIDTH:0] remainder;
   logic [FREQ_WIDTH-1:0] dividend;
   logic [$clog2(DIV_STEPS+1)-1:0] div_count;
   logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_count;
   logic second_larger;
   logic [FREQ_WIDTH-1:0] harmonic_round;
   logic [2*FREQ_WIDTH-1:0] product;
   logic [FREQ_WIDTH:0] next_remainder;

   // detector level comes from the analog side: three stages, act when last two agree
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         band_sync <= '0;
         band_ok <= 1'b0;
      end
      else
      begin
         band_sync <= {band_sync[1:0], if_in_band};
         if (band_sync[2] == band_sync[1])
         begin
            band_ok <= band_sync[2];
         end
      end
   end

   // restoring divider step against the fixed offset
   always_comb
   begin
      next_remainder = {remainder[FREQ_WIDTH-1:0], dividend[FREQ_WIDTH-1]};
      if (next_remainder >= {1'b0, OFFSET_HZ})
      begin
         next_remainder = next_remainder - {1'b0, OFFSET_HZ};
      end
   end

   always_comb
   begin
      harmonic_round = quotient;
      // remainder at or above half the offset rounds up
      if ({remainder[FREQ_WIDTH-1:0], 1'b0} >= OFFSET_HZ)
      begin
         harmonic_round = quotient + 1'b1;
      end
   end

   assign product = first_local_frequency * quotient;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= HHC_IDLE;
         sweep_frequency <= START_HZ;
         first_local_frequency <= '0;
         second_local_frequency <= '0;
         first_intermediate_count <= '0;
         second_intermediate_count <= '0;
         second_larger <= 1'b0;
         quotient <= '0;
         remainder <= '0;
         dividend <= '0;
         div_count <= '0;
         settle_count <= '0;
         synth <= '0;
         counter_cmd <= '0;
         result <= '0;
         no_signal <= 1'b0;
      end
      else
      begin
         synth.load <= 1'b0;
         counter_cmd.start <= 1'b0;
         result.valid <= 1'b0;
         unique case (state)
            HHC_IDLE:
            begin
               if (start)
               begin
                  no_signal <= 1'b0;
                  sweep_frequency <= START_HZ;
                  synth.frequency <= START_HZ;
                  synth.load <= 1'b1;
                  settle_count <= '0;
                  state <= HHC_SWEEP;
               end
            end
            HHC_SWEEP:
            begin
               // wait for the synthesizer and detector to settle at each step
               // settle must cover the five-cycle detector lag or band_ok is stale
               if (settle_count != SETTLE_CYCLES[$bits(settle_count)-1:0])
               begin
                  settle_count <= settle_count + 1'b1;
               end
               else if (band_ok)
               begin
                  first_local_frequency <= sweep_frequency;
                  counter_cmd.start <= 1'b1;
                  state <= HHC_COUNT1;
               end
               else if (sweep_frequency <= STOP_HZ)
               begin
                  // whole span swept without a countable IF
                  no_signal <= 1'b1;
                  state <= HHC_IDLE;
               end
               else
               begin
                  sweep_frequency <= sweep_frequency - STEP_HZ;
                  synth.frequency <= sweep_frequency - STEP_HZ;
                  synth.load <= 1'b1;
                  settle_count <= '0;
               end
            end
            HHC_COUNT1:
            begin
               if (count_done)
               begin
                  first_intermediate_count <= count_value;
                  second_local_frequency <= first_local_frequency - OFFSET_HZ;
                  synth.frequency <= first_local_frequency - OFFSET_HZ;
                  synth.load <= 1'b1;
                  settle_count <= '0;
                  state <= HHC_SETTLE;
               end
            end
            HHC_SETTLE:
            begin
               if (settle_count != SETTLE_CYCLES[$bits(settle_count)-1:0])
               begin
                  settle_count <= settle_count + 1'b1;
               end
               else
               begin
                  counter_cmd.start <= 1'b1;
                  state <= HHC_COUNT2;
               end
            end
            HHC_COUNT2:
            begin
               if (count_done)
               begin
                  second_intermediate_count <= count_value;
                  second_larger <= count_value > first_intermediate_count;
                  if (count_value > first_intermediate_count)
                  begin
                     dividend <= count_value - first_intermediate_count;
                  end
                  else
                  begin
                     dividend <= first_intermediate_count - count_value;
                  end
                  quotient <= '0;
                  remainder <= '0;
                  div_count <= '0;
                  state <= HHC_DIVIDE;
               end
            end
            HHC_DIVIDE:
            begin
               // one quotient bit per cycle keeps the divider small
               remainder <= next_remainder;
               quotient <= {quotient[FREQ_WIDTH-2:0],
                  {remainder[FREQ_WIDTH-1:0], dividend[FREQ_WIDTH-1]} >= {1'b0, OFFSET_HZ}};
               dividend <= {dividend[FREQ_WIDTH-2:0], 1'b0};
               div_count <= div_count + 1'b1;
               if (div_count == DIV_STEPS[$bits(div_count)-1:0] - 1'b1)
               begin
                  state <= HHC_ROUND;
               end
            end
            HHC_ROUND:
            begin
               quotient <= harmonic_round;
               state <= HHC_RESULT;
            end
            HHC_RESULT:
            begin
               result.valid <= 1'b1;
               result.harmonic <= quotient[HARM_WIDTH-1:0];
               // larger second count means harmonic product sits below the unknown
               result.negative_if <= !second_larger;
               if (second_larger)
               begin
                  result.unknown_input_frequency <= product[FREQ_WIDTH-1:0]
                     + first_intermediate_count;
               end
               else
               begin
                  result.unknown_input_frequency <= product[FREQ_WIDTH-1:0]
                     - first_intermediate_count;
               end
               state <= HHC_IDLE;
            end
            HHC_RETUNE, HHC_FAIL:
            begin
               state <= HHC_IDLE;
            end
         endcase
      end
   end

   assign busy = (state != HHC_IDLE);
endmodule

//--- hhc_compute_assertions.sv
// concurrent checks on the ports of the harmonic heterodyne controller
module hhc_compute_assertions
   import hhc_pkg::*;
#(
   parameter int SETTLE_CYCLES = 16
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic if_in_band,
   input hhc_pkg::hhc_synth_type synth,
   input hhc_pkg::hhc_count_type counter_cmd,
   input wire logic count_done,
   input wire logic [hhc_pkg::FREQ_WIDTH-1:0] count_value,
   input hhc_pkg::hhc_result_type result,
   input wire logic busy,
   input wire logic no_signal
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ncd;
   logic [FREQ_WIDTH-1:0] last_f;
   logic [FREQ_WIDTH-1:0] first_local_frequency;
   logic [FREQ_WIDTH-1:0] c1;
   logic [FREQ_WIDTH-1:0] c2;
   logic [FREQ_WIDTH-1:0] dc;
   logic [FREQ_WIDTH-1:0] nf;
   wire logic ld = synth.load;
   wire logic [FREQ_WIDTH-1:0] fq = synth.frequency;
   assign dc = (c2 > c1) ? c2 - c1 : c1 - c2;
   assign nf = FREQ_WIDTH'(result.harmonic) * first_local_frequency;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ncd counts completed counts of the running measurement
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ncd <= 2'h0;
         last_f <= '0;
         first_local_frequency <= '0;
         c1 <= '0;
         c2 <= '0;
      end
      else
      begin
         if (start && !busy)
            ncd <= 2'h0;
         else if (count_done && busy && ncd != 2'h2)
            ncd <= ncd + 2'h1;
         if (ld)
            last_f <= fq;
         if (count_done && busy && ncd == 2'h0)
         begin
            first_local_frequency <= last_f;
            c1 <= count_value;
         end
         if (count_done && busy && ncd == 2'h1)
            c2 <= count_value;
      end
   end
   AST_LOAD_AFTER_START: assert property (start && !busy |=> ld && fq == START_HZ)
      else $error("first synthesizer load missing");
   AST_SWEEP_STEP: assert property (ld && ncd == 2'h0 && fq != START_HZ |->
      fq == last_f - STEP_HZ) else $error("sweep step wrong");
   AST_BAND_HALT: assert property (ld && ncd == 2'h0 ##1 if_in_band |=> !ld [*8])
      else $error("sweep kept stepping in band");
   AST_BAND_COUNT: assert property ($rose(if_in_band) && busy && ncd == 2'h0 |->
      ##[1:24] counter_cmd.start) else $error("first count not started");
   AST_RETUNE: assert property (ld && ncd == 2'h1 |-> fq == first_local_frequency - OFFSET_HZ)
      else $error("retune offset wrong");
   AST_RESULT_SOON: assert property (count_done && busy && ncd == 2'h1 |->
      ##[30:80] result.valid) else $error("result late");
   AST_HARMONIC: assert property (result.valid |->
      result.harmonic == HARM_WIDTH'((dc + (OFFSET_HZ >> 1)) / OFFSET_HZ))
      else $error("harmonic wrong");
   AST_UNKNOWN: assert property (result.valid |-> result.negative_if == !(c2 > c1) &&
      result.unknown_input_frequency == ((c2 > c1) ? nf + c1 : nf - c1))
      else $error("unknown frequency wrong");
   cover property (result.valid && result.negative_if);
   cover property (result.valid && !result.negative_if);
   cover property ($rose(no_signal));
endmodule

bind hhc_compute hhc_compute_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) hhc_compute_assertions_inst
   (.clk, .reset_n, .start, .if_in_band, .synth, .counter_cmd, .count_done, .count_value,
   .result, .busy, .no_signal);

//--- hhc_far_side.sv
// far side model: synthesizer, IF detector and IF counter
module hhc_far_side
   import hhc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [FREQ_WIDTH-1:0] unknown_input_frequency,
   input wire logic slow,
   input hhc_pkg::hhc_synth_type synth,
   input hhc_pkg::hhc_count_type counter_cmd,
   output logic if_in_band,
   output logic count_done,
   output logic [FREQ_WIDTH-1:0] count_value
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [FREQ_WIDTH-1:0] f;
   logic [FREQ_WIDTH-1:0] k;
   logic [FREQ_WIDTH-1:0] ifq;
   logic [3:0] wait_n;
   logic run;
   always_comb
   begin
      k = (f == '0) ? '0 : (unknown_input_frequency + (f >> 1)) / f;
      ifq = (unknown_input_frequency > k * f) ? unknown_input_frequency - k * f
         : k * f - unknown_input_frequency;
   end
   assign if_in_band = ifq >= 40'h0002FAF080 && ifq <= 40'h0005F5E100;
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         f <= '0;
         run <= 1'b0;
         wait_n <= 4'h0;
         count_done <= 1'b0;
         count_value <= '0;
      end
      else
      begin
         count_done <= 1'b0;
         // outside the done pulse the bus toggles between the last count and its inverse
         count_value <= ~count_value;
         if (synth.load)
            f <= synth.frequency;
         if (counter_cmd.start)
         begin
            run <= 1'b1;
            wait_n <= slow ? 4'hC : 4'h1;
         end
         else if (run && wait_n != 4'h0)
            wait_n <= wait_n - 4'h1;
         else if (run)
         begin
            run <= 1'b0;
            count_done <= 1'b1;
            count_value <= ifq;
         end
      end
   end
endmodule

//--- harmonic_heterodyne_compute_tb_top.sv
// testbench for the harmonic heterodyne measurement controller
module harmonic_heterodyne_compute_tb_top import hhc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset_n, start, slow, if_in_band, count_done, busy, no_signal;
   logic [FREQ_WIDTH-1:0] unknown_input_frequency, count_value;
   hhc_synth_type synth;
   hhc_count_type counter_cmd;
   hhc_result_type result;
   int seed = 70;
   int n_errors = 0;
   int checked = 0;
   hhc_compute #(.SETTLE_CYCLES(8)) hhc_compute_inst (.clk, .reset_n, .start, .if_in_band,
      .synth, .counter_cmd, .count_done, .count_value, .result, .busy, .no_signal);
   hhc_far_side hhc_far_side_inst (.clk, .reset_n, .unknown_input_frequency, .slow, .synth,
      .counter_cmd,
      .if_in_band, .count_done, .count_value);
   always #50 clk = ~clk;
   function automatic logic [39:0] if_hz(input logic [39:0] x, input logic [39:0] f);
      logic [39:0] k;
      k = (x + (f >> 1)) / f;
      return (x > k * f) ? x - k * f : k * f - x;
   endfunction
   function automatic logic band(input logic [39:0] v);
      return v >= IF_LOW_MHZ * 40'hF4240 && v <= IF_HIGH_MHZ * 40'hF4240;
   endfunction
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic run(input logic [39:0] x, input logic s);
      logic [39:0] first_local_frequency, c1, c2, n, e;
      int i;
      first_local_frequency = START_HZ;
      while (first_local_frequency >= STOP_HZ && !band(if_hz(x, first_local_frequency)))
         first_local_frequency = first_local_frequency - STEP_HZ;
      c1 = if_hz(x, first_local_frequency);
      c2 = if_hz(x, first_local_frequency - OFFSET_HZ);
      n = (((c1 > c2) ? c1 - c2 : c2 - c1) + (OFFSET_HZ >> 1)) / OFFSET_HZ;
      e = (c2 > c1) ? n * first_local_frequency + c1 : n * first_local_frequency - c1;
      @(posedge clk);
      unknown_input_frequency <= x;
      slow <= s;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (4) @(posedge clk);
      check(busy, 1'b1);
      // a second start in mid-measurement must be ignored
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      i = 0;
      // falling-edge sampling sees the one-cycle result pulse settled
      while (result.valid !== 1'b1 && no_signal !== 1'b1 && i < 12000)
      begin
         @(negedge clk);
         i++;
      end
      if (i == 12000)
         n_errors++;
      check(no_signal, first_local_frequency < STOP_HZ);
      if (first_local_frequency >= STOP_HZ)
      begin
         check(result.harmonic, n);
         check(result.negative_if, c2 <= c1);
         check(result.unknown_input_frequency, e);
         check(result.unknown_input_frequency, x);
      end
      $display("test done input %h", x);
   endtask
   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      start = 1'b0;
      slow = 1'b0;
      unknown_input_frequency = '0;
      repeat (10) @(posedge clk);
      check(busy, 1'b0);
      reset_n <= 1'b1;
      run(40'h0, 1'b0);
      run(40'h002E318FC0, 1'b1);
      run(40'h003B023380, 1'b0);
      for (int t = 0; t < 6; t++)
         run(40'({$random(seed)}) * 40'h4 + 40'h003B9ACA00, t[0]);
      results;
   end
   initial
   begin
      #6000000;
      n_errors++;
      results;
   end
endmodule
